// ---- idc_map.vh ----
// register map, field layout, reset values and timing for the id/crc/wake register bank
`ifndef IDC_MAP_VH
`define IDC_MAP_VH
// ----------------------------------------------------------------------------
// register offsets (7-bit address)
// ----------------------------------------------------------------------------
`define IDC_OFF_PART_LAST   7'h07
`define IDC_OFF_REV_MAJOR   7'h08
`define IDC_OFF_REV_MINOR   7'h09
`define IDC_OFF_FCC         7'h0A
`define IDC_OFF_POLY        7'h0B
`define IDC_OFF_SCRATCH     7'h0F
`define IDC_OFF_WAKE1       7'h11
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IDC_FCC_RST         8'h00
`define IDC_POLY_RST        8'h00
`define IDC_SCRATCH_RST     8'h00
`define IDC_WAKE1_RST       8'h04
// ----------------------------------------------------------------------------
// wake config one field positions
// ----------------------------------------------------------------------------
`define IDC_WK_EDGE_HI      7
`define IDC_WK_EDGE_LO      6
`define IDC_WK_STAT_HI      5
`define IDC_WK_STAT_LO      4
`define IDC_WK_INV_HI       3
`define IDC_WK_INV_LO       2
`define IDC_WK_MAX_HI       1
`define IDC_WK_MAX_LO       0
// ----------------------------------------------------------------------------
// wake edge selection and status codes
// ----------------------------------------------------------------------------
`define IDC_EDGE_RISE       2'h0
`define IDC_EDGE_BOTH       2'h1
`define IDC_EDGE_FALL       2'h2
`define IDC_EDGE_PULSE      2'h3
`define IDC_STAT_NONE       2'h0
`define IDC_STAT_RISE       2'h1
`define IDC_STAT_FALL       2'h2
`define IDC_STAT_PULSE      2'h3
// ----------------------------------------------------------------------------
// frame check polynomials and frame lengths
// ----------------------------------------------------------------------------
`define IDC_POLY_A          8'h2F
`define IDC_POLY_B          8'h1D
`define IDC_CRC_INIT        8'hFF
`define IDC_BITS_PLAIN      5'h10
`define IDC_BITS_CRC        5'h18
// ----------------------------------------------------------------------------
// timing: wake widths in ms, tick derived from clock
// ----------------------------------------------------------------------------
`define IDC_CLK_PERIOD_NS   10
`define IDC_T_TICK_NS       1000000
`define IDC_TICK_CYCLES     (`IDC_T_TICK_NS / `IDC_CLK_PERIOD_NS)
`define IDC_T_INV0_MS       12'h005
`define IDC_T_INV1_MS       12'h00A
`define IDC_T_INV2_MS       12'h014
`define IDC_T_INV3_MS       12'h028
`define IDC_T_MIN0_MS       12'h00A
`define IDC_T_MIN1_MS       12'h014
`define IDC_T_MIN2_MS       12'h028
`define IDC_T_MIN3_MS       12'h050
`define IDC_T_MAX0_MS       12'h2EE
`define IDC_T_MAX1_MS       12'h3E8
`define IDC_T_MAX2_MS       12'h5DC
`define IDC_T_MAX3_MS       12'h7D0
`endif

// ---- idc_wake_qual.v ----
// wake pin edge detector and pulse width qualifier
`timescale 1ns/1ps
`include "idc_map.vh"
module idc_wake_qual #(
  parameter TICK_CYCLES = `IDC_TICK_CYCLES
) (
  // system
  input  wire       clk_sys,
  input  wire       rst_n,
  // pin
  input  wire       wake_pin,
  // configuration
  input  wire [1:0] edge_sel,
  input  wire [1:0] inv_sel,
  input  wire [1:0] max_sel,
  // event
  output reg        evt_valid,
  output reg  [1:0] evt_code
);

  reg        sync1_reg;
  reg        sync2_reg;
  reg        sync3_reg;
  reg [31:0] tick_cnt_reg;
  reg [11:0] width_reg;
  reg [11:0] inv_ms;
  reg [11:0] min_ms;
  reg [11:0] max_ms;
  wire       rise = sync2_reg & ~sync3_reg;
  wire       fall = ~sync2_reg & sync3_reg;
  wire       tick = (tick_cnt_reg == TICK_CYCLES - 1);
  wire       pulse_ok;

  // ----------------------------------------------------------------------------
  // width limits from config codes
  // ----------------------------------------------------------------------------
  always @* begin
    case (inv_sel) // RL8
      2'h0:    begin inv_ms = `IDC_T_INV0_MS; min_ms = `IDC_T_MIN0_MS; end
      2'h1:    begin inv_ms = `IDC_T_INV1_MS; min_ms = `IDC_T_MIN1_MS; end
      2'h2:    begin inv_ms = `IDC_T_INV2_MS; min_ms = `IDC_T_MIN2_MS; end
      default: begin inv_ms = `IDC_T_INV3_MS; min_ms = `IDC_T_MIN3_MS; end
    endcase
    case (max_sel) // RL9
      2'h0:    max_ms = `IDC_T_MAX0_MS;
      2'h1:    max_ms = `IDC_T_MAX1_MS;
      2'h2:    max_ms = `IDC_T_MAX2_MS;
      default: max_ms = `IDC_T_MAX3_MS;
    endcase
  end

  // reject at or below threshold, accept from min to max
  assign pulse_ok = (width_reg > inv_ms) && (width_reg >= min_ms) // RL8
                    && (width_reg <= max_ms); // RL9

  // ----------------------------------------------------------------------------
  // pin sync, ms tick and high-phase width count
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg    <= 1'b0;
      sync2_reg    <= 1'b0;
      sync3_reg    <= 1'b0;
      tick_cnt_reg <= 32'h0000_0000;
      width_reg    <= 12'h000;
    end else begin
      sync1_reg <= wake_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (rise || tick)
        tick_cnt_reg <= 32'h0000_0000; // restart tick at pulse start
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      if (rise)
        width_reg <= 12'h000;
      else if (sync2_reg && tick && width_reg != 12'hFFF)
        width_reg <= width_reg + 12'h001; // saturating ms count
    end
  end

  // ----------------------------------------------------------------------------
  // event generation per edge selection
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_valid <= 1'b0;
      evt_code  <= `IDC_STAT_NONE;
    end else begin
      evt_valid <= 1'b0;
      case (edge_sel) // RL10
        `IDC_EDGE_RISE: begin
          if (rise) begin
            evt_valid <= 1'b1;
            evt_code  <= `IDC_STAT_RISE;
          end
        end
        `IDC_EDGE_FALL: begin
          if (fall) begin
            evt_valid <= 1'b1;
            evt_code  <= `IDC_STAT_FALL;
          end
        end
        `IDC_EDGE_BOTH: begin
          if (rise || fall) begin
            evt_valid <= 1'b1;
            evt_code  <= rise ? `IDC_STAT_RISE : `IDC_STAT_FALL;
          end
        end
        default: begin
          if (fall && pulse_ok) begin
            evt_valid <= 1'b1;
            evt_code  <= `IDC_STAT_PULSE;
          end
        end
      endcase
    end
  end

endmodule // idc_wake_qual

// ---- idc_regs.v ----
// spi register bank: part number, revision, frame check, scratch, wake config one
//
// Overview of operation
// [RL1] offsets 0 to 7 read the eight part number characters and writes never change them.
// [RL2] bit 0 of the frame check control turns frame checking on, and it is off after reset.
// [RL3] bit 0 of the polynomial select picks 0x2F when 0 and 0x1D when 1 for the frame crc.
// [RL4] the polynomial select resets to zero so 0x2F is used until software changes it.
// [RL5] the scratch register resets to zero and reads back whatever was written.
// [RL6] bits 7 to 1 of frame check control and polynomial select read zero and ignore writes.
// [RL7] bits 5-4 of wake config one hold the last wake event, set by hardware, cleared by zeros.
// [RL8] bits 3-2, reset 01, choose the invalid threshold and the minimum valid pulse width.
// [RL9] bits 1-0, reset 00, choose the longest wake pulse still counted as valid.
// [RL10] bits 7-6, reset 00, choose which wake pin transition raises a wake.
`timescale 1ns/1ps
`include "idc_map.vh"
module idc_regs #(
  parameter [63:0] PART_NUMBER = 64'h4142_4344_4546_4733, // arbitrary value
  parameter [7:0]  REV_MAJOR   = 8'h0A,                   // arbitrary value
  parameter [7:0]  REV_MINOR   = 8'h0B,                   // arbitrary value
  parameter        TICK_CYCLES = `IDC_TICK_CYCLES
) (
  // system
  input  wire clk_sys,
  input  wire rst_n,
  // spi target
  input  wire spi_sclk,
  input  wire spi_cs_n,
  input  wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  // wake pin
  input  wire wake_pin,
  // status and control out
  output wire frame_check_on,
  output wire polynomial_choice_bit,
  output wire wake_request,
  output wire frame_check_error
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg  [2:0] sync3_reg;
  reg  [4:0] bit_cnt_reg;
  reg  [7:0] rx_shift_reg;
  reg  [7:0] cmd_reg;
  reg  [7:0] data_rx_reg;
  reg  [7:0] crc_rx_reg;
  reg  [7:0] crc_tx_reg;
  reg  [7:0] tx_shift_reg;
  reg        miso_reg;
  reg        miso_oe_reg;
  reg        crc_en_reg;
  reg        poly_sel_reg;
  reg  [7:0] scratch_reg;
  reg  [1:0] wk_edge_reg;
  reg  [1:0] wk_stat_reg;
  reg  [1:0] wk_inv_reg;
  reg  [1:0] wk_max_reg;
  reg        wake_req_reg;
  reg        crc_err_reg;
  reg  [7:0] rdata;
  // reset words held at full width so each field is cut out on purpose
  localparam [7:0] FCC_RST   = `IDC_FCC_RST;
  localparam [7:0] POLY_RST  = `IDC_POLY_RST;
  localparam [7:0] WAKE1_RST = `IDC_WAKE1_RST;
  wire [7:0] poly;
  wire [7:0] rx_next;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_act;
  wire       cs_start;
  wire       cs_end;
  wire       mosi_s;
  wire       len_ok;
  wire       crc_ok;
  wire       wr_ok;
  wire       wk_evt;
  wire [1:0] wk_code;

  // ----------------------------------------------------------------------------
  // crc over one byte, msb first
  // ----------------------------------------------------------------------------
  function [7:0] crc8;
    input [7:0] crc_in;
    input [7:0] byte_in;
    input [7:0] p;
    integer i;
    reg [7:0] c;
    begin
      c = crc_in;
      for (i = 7; i >= 0; i = i - 1) begin
        if (c[7] ^ byte_in[i])
          c = {c[6:0], 1'b0} ^ p;
        else
          c = {c[6:0], 1'b0};
      end
      crc8 = c;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------------
  // registers come in as arguments so the caller's sensitivity sees them change
  function [7:0] reg_read;
    input [6:0] a;
    input       fcc_bit;
    input       poly_bit;
    input [7:0] scr;
    input [7:0] wk;
    begin
      if (a <= `IDC_OFF_PART_LAST)
        reg_read = PART_NUMBER[(7 - a[2:0]) * 8 +: 8]; // RL1
      else begin
        case (a)
          `IDC_OFF_REV_MAJOR: reg_read = REV_MAJOR;
          `IDC_OFF_REV_MINOR: reg_read = REV_MINOR;
          `IDC_OFF_FCC:       reg_read = {7'h00, fcc_bit};  // RL6
          `IDC_OFF_POLY:      reg_read = {7'h00, poly_bit}; // RL6
          `IDC_OFF_SCRATCH:   reg_read = scr;               // RL5
          `IDC_OFF_WAKE1:     reg_read = wk;
          default:            reg_read = 8'h00;
        endcase
      end
    end
  endfunction

  always @* begin
    rdata = reg_read(rx_next[6:0], crc_en_reg, poly_sel_reg, scratch_reg,
                     {wk_edge_reg, wk_stat_reg, wk_inv_reg, wk_max_reg});
  end

  // ----------------------------------------------------------------------------
  // pin sync and edge finding
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= 3'h3;
      sync2_reg <= 3'h3;
      sync3_reg <= 3'h3;
    end else begin
      sync1_reg <= {spi_sclk, spi_cs_n, spi_mosi};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign sclk_rise = sync2_reg[2] & ~sync3_reg[2];
  assign sclk_fall = ~sync2_reg[2] & sync3_reg[2];
  assign cs_act    = ~sync2_reg[1];
  assign cs_start  = ~sync2_reg[1] & sync3_reg[1];
  assign cs_end    = sync2_reg[1] & ~sync3_reg[1];
  assign mosi_s    = sync2_reg[0];
  assign rx_next   = {rx_shift_reg[6:0], mosi_s};
  assign poly      = poly_sel_reg ? `IDC_POLY_B : `IDC_POLY_A; // RL3

  // frame acceptance: length per crc mode, crc byte must match
  assign len_ok = crc_en_reg ? (bit_cnt_reg == `IDC_BITS_CRC) : (bit_cnt_reg == `IDC_BITS_PLAIN);
  assign crc_ok = ~crc_en_reg | (rx_shift_reg == crc_rx_reg); // RL2
  assign wr_ok  = cs_end & cmd_reg[7] & len_ok & crc_ok;

  // ----------------------------------------------------------------------------
  // spi frame engine: cmd byte, data byte, optional crc byte
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      bit_cnt_reg  <= 5'h00;
      rx_shift_reg <= 8'h00;
      cmd_reg      <= 8'h00;
      data_rx_reg  <= 8'h00;
      crc_rx_reg   <= 8'h00;
      crc_tx_reg   <= 8'h00;
      tx_shift_reg <= 8'h00;
      miso_reg     <= 1'b0;
      miso_oe_reg  <= 1'b0;
      crc_err_reg  <= 1'b0;
    end else begin
      crc_err_reg <= cs_end & crc_en_reg & ~(len_ok & crc_ok); // RL2
      if (cs_start) begin
        bit_cnt_reg  <= 5'h00;
        tx_shift_reg <= 8'h00;
        miso_reg     <= 1'b0;
        miso_oe_reg  <= 1'b1;
      end else if (cs_end) begin
        miso_oe_reg <= 1'b0;
      end else if (cs_act && sclk_rise) begin
        rx_shift_reg <= rx_next;
        if (bit_cnt_reg != 5'h1F)
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == 5'h07) begin
          cmd_reg      <= rx_next;
          crc_rx_reg   <= crc8(`IDC_CRC_INIT, rx_next, poly); // RL3
          tx_shift_reg <= rdata;
          crc_tx_reg   <= crc8(crc8(`IDC_CRC_INIT, rx_next, poly), rdata, poly); // RL3
        end else if (bit_cnt_reg == 5'h0F) begin
          data_rx_reg  <= rx_next;
          crc_rx_reg   <= crc8(crc_rx_reg, rx_next, poly);
          tx_shift_reg <= crc_tx_reg;
        end
      end else if (cs_act && sclk_fall) begin
        miso_reg     <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // writable registers, committed at frame end
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      crc_en_reg   <= FCC_RST[0];                                  // RL2
      poly_sel_reg <= POLY_RST[0];                                 // RL4
      scratch_reg  <= `IDC_SCRATCH_RST;                            // RL5
      wk_edge_reg  <= WAKE1_RST[`IDC_WK_EDGE_HI:`IDC_WK_EDGE_LO]; // RL10
      wk_inv_reg   <= WAKE1_RST[`IDC_WK_INV_HI:`IDC_WK_INV_LO];   // RL8
      wk_max_reg   <= WAKE1_RST[`IDC_WK_MAX_HI:`IDC_WK_MAX_LO];   // RL9
    end else if (wr_ok) begin
      case (cmd_reg[6:0])
        `IDC_OFF_FCC:     crc_en_reg   <= data_rx_reg[0]; // RL2
        `IDC_OFF_POLY:    poly_sel_reg <= data_rx_reg[0]; // RL3
        `IDC_OFF_SCRATCH: scratch_reg  <= data_rx_reg;    // RL5
        `IDC_OFF_WAKE1: begin
          wk_edge_reg <= data_rx_reg[`IDC_WK_EDGE_HI:`IDC_WK_EDGE_LO]; // RL10
          wk_inv_reg  <= data_rx_reg[`IDC_WK_INV_HI:`IDC_WK_INV_LO];   // RL8
          wk_max_reg  <= data_rx_reg[`IDC_WK_MAX_HI:`IDC_WK_MAX_LO];   // RL9
        end
        default: ; // read-only and unmapped offsets ignore writes
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // wake status: hardware set beats host clear
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wk_stat_reg  <= `IDC_STAT_NONE;
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= wk_evt;
      if (wk_evt)
        wk_stat_reg <= wk_code; // RL7
      else if (wr_ok && cmd_reg[6:0] == `IDC_OFF_WAKE1)
        wk_stat_reg <= wk_stat_reg & data_rx_reg[`IDC_WK_STAT_HI:`IDC_WK_STAT_LO]; // RL7
    end
  end

  // ----------------------------------------------------------------------------
  // wake qualifier
  // ----------------------------------------------------------------------------
  idc_wake_qual #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wake (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .wake_pin  (wake_pin),
    .edge_sel  (wk_edge_reg),
    .inv_sel   (wk_inv_reg),
    .max_sel   (wk_max_reg),
    .evt_valid (wk_evt),
    .evt_code  (wk_code)
  );

  // outputs straight from flops
  assign spi_miso              = miso_reg;
  assign spi_miso_oe           = miso_oe_reg;
  assign frame_check_on        = crc_en_reg;
  assign polynomial_choice_bit = poly_sel_reg;
  assign wake_request          = wake_req_reg;
  assign frame_check_error     = crc_err_reg;

endmodule // idc_regs

// ---- idc_regs_props.sv ----
// concurrent checks at the ports of the id/crc/wake register bank
`timescale 1ns/1ps
module idc_regs_props (
  // system
  input wire clk_sys,
  input wire rst_n,
  // spi target
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire spi_miso,
  input wire spi_miso_oe,
  // wake pin
  input wire wake_pin,
  // status and control
  input wire frame_check_on,
  input wire polynomial_choice_bit,
  input wire wake_request,
  input wire frame_check_error
);
  reg [3:0] since_pin_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------
  // cycles since the wake pin last moved
  // ---------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n)
      since_pin_reg <= 4'hF;
    else if ($changed(wake_pin))
      since_pin_reg <= 4'h0;
    else if (since_pin_reg != 4'hF)
      since_pin_reg <= since_pin_reg + 4'h1;
  end
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  chk_reset_quiet: assert property ($rose(rst_n) |-> !frame_check_on &&
    !polynomial_choice_bit && !spi_miso_oe && !wake_request)
    else $error("outputs not at rest after reset");
  chk_fc_commit: assert property (!$stable(frame_check_on) |->
    $past(spi_cs_n) && $past(spi_cs_n, 2)) else $error("check enable moved inside a frame");
  chk_poly_commit: assert property (!$stable(polynomial_choice_bit) |->
    $past(spi_cs_n) && $past(spi_cs_n, 2)) else $error("poly select moved inside a frame");
  chk_err_gate: assert property (frame_check_error |-> frame_check_on && spi_cs_n)
    else $error("frame error while checking off or inside frame");
  chk_err_pulse: assert property (frame_check_error |=> !frame_check_error)
    else $error("frame error longer than one cycle");
  chk_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  chk_wake_cause: assert property (wake_request |->
    since_pin_reg >= 4'h1 && since_pin_reg <= 4'hA) else $error("wake request without pin move");
  chk_oe_follow: assert property ($fell(spi_cs_n) |-> ##[1:6] spi_miso_oe)
    else $error("read driver not enabled in frame");
  chk_oe_idle: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("read driver enabled outside frame");
endmodule // idc_regs_props
bind idc_regs idc_regs_props i_idc_regs_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .wake_pin(wake_pin),
  .frame_check_on(frame_check_on), .polynomial_choice_bit(polynomial_choice_bit),
  .wake_request(wake_request), .frame_check_error(frame_check_error));

// ---- idc_host.sv ----
// spi controller model that frames register accesses, mode 0, msb first
`timescale 1ns/1ps
module idc_host (
  // system
  input  wire clk_sys,
  // spi link
  output reg  spi_sclk,
  output reg  spi_cs_n,
  output reg  spi_mosi,
  input  wire spi_miso,
  input  wire spi_miso_oe
);
  reg last_miso;
  // ---------------------------------------------
  // idle link: clock low, deselected
  // ---------------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    last_miso = 1'b0;
  end
  // one frame: n bits from the top of tx, reply shifted into rx
  task xfer(input [23:0] tx, input int n, output [23:0] rx);
    int i;
    rx = 24'h00_0000;
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < n; i++) begin
      spi_mosi <= tx[23-i];
      repeat (8) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      // undriven line: no stale copy of the last bit
      last_miso = spi_miso_oe ? spi_miso : ~last_miso;
      rx = {rx[22:0], last_miso};
      repeat (8) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // idc_host

// ---- tb_top.sv ----
// self-checking bench for the id/crc/wake register bank
`timescale 1ns/1ps
module tb_top;
  localparam int        TK   = 10;
  localparam bit [63:0] PN   = 64'h6162_6364_6566_6768; // arbitrary value
  localparam bit [7:0]  RMAJ = 8'h2A;                   // arbitrary value
  localparam bit [7:0]  RMIN = 8'h2B;                   // arbitrary value
  reg        clk_sys, rst_n, wake_pin;
  wire       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire       frame_check_on, polynomial_choice_bit, wake_request, frame_check_error;
  reg  [7:0] fcc_m, poly_m, scr_m, wk_m, rdat;
  reg  [6:0] ra;
  reg [23:0] rx;
  int        n_mismatch, samples_checked, n_wake, n_err, k, c0;
  int        pw [8] = '{3, 15, 15, 45, 800, 800, 85, 1100};
  int        pi [8] = '{0, 0, 1, 2, 0, 0, 3, 0};
  int        pm [8] = '{0, 0, 0, 0, 0, 1, 3, 2};
  int        em [4] = '{0, 2, 1, 1};
  idc_regs #(.PART_NUMBER(PN), .REV_MAJOR(RMAJ), .REV_MINOR(RMIN), .TICK_CYCLES(TK)) i_idc_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .wake_pin(wake_pin),
    .frame_check_on(frame_check_on), .polynomial_choice_bit(polynomial_choice_bit),
    .wake_request(wake_request), .frame_check_error(frame_check_error));
  idc_host i_idc_host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // ---------------------------------------------
  // clock and pulse counters
  // ---------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (wake_request === 1'b1) n_wake++;
    if (frame_check_error === 1'b1) n_err++;
  end
  // ---------------------------------------------
  // expectations
  // ---------------------------------------------
  function [7:0] crc8(input sel, input [15:0] v);
    int i;
    reg [7:0] c;
    c = 8'hFF;
    for (i = 15; i >= 0; i--)
      c = (c[7] ^ v[i]) ? ({c[6:0], 1'b0} ^ (sel ? 8'h1D : 8'h2F)) : {c[6:0], 1'b0};
    return c;
  endfunction
  function [7:0] exp_rd(input [6:0] a);
    case (a)
      7'h08: return RMAJ;
      7'h09: return RMIN;
      7'h0A: return fcc_m;
      7'h0B: return poly_m;
      7'h0F: return scr_m;
      7'h11: return wk_m;
      default: return (a < 7'h08) ? PN[63 - 8 * a -: 8] : 8'h00;
    endcase
  endfunction
  function bit pulse_ok(input int w, input int inv, input int mx);
    int th;
    th = 5 << inv;
    return w > th && w >= 2 * th && w <= (mx == 0 ? 750 : 500 * (mx + 1));
  endfunction
  // ---------------------------------------------
  // compare, frames, reset, verdict
  // ---------------------------------------------
  task chk(input string nm, input [7:0] e, input [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d, input bad);
    reg [15:0] h;
    h = {1'b1, a, d};
    i_idc_host.xfer({h, crc8(poly_m[0], h) ^ {7'h00, bad}}, fcc_m[0] ? 24 : 16, rx);
    if (!bad && a == 7'h0A) fcc_m = {7'h00, d[0]};
    if (!bad && a == 7'h0B) poly_m = {7'h00, d[0]};
    if (!bad && a == 7'h0F) scr_m = d;
    if (!bad && a == 7'h11) wk_m = {d[7:6], wk_m[5:4] & d[5:4], d[3:0]};
  endtask
  task rd(input [6:0] a);
    reg [7:0] e;
    e = exp_rd(a);
    i_idc_host.xfer({1'b0, a, 8'h00, crc8(poly_m[0], {1'b0, a, 8'h00})}, fcc_m[0] ? 24 : 16, rx);
    if (fcc_m[0]) begin
      chk("rd_data", e, rx[15:8]);
      chk("rd_crc", crc8(poly_m[0], {1'b0, a, e}), rx[7:0]);
    end else begin
      chk("rd_data", e, rx[7:0]);
    end
    chk("check_on", {7'h00, fcc_m[0]}, {7'h00, frame_check_on});
    chk("poly_bit", {7'h00, poly_m[0]}, {7'h00, polynomial_choice_bit});
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    fcc_m = 8'h00;
    poly_m = 8'h00;
    scr_m = 8'h00;
    wk_m = 8'h04;
    repeat (4) @(posedge clk_sys);
    for (k = 0; k < 20; k++) rd(k[6:0]);
    rd(7'h7F);
    $display("test reset_values done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst_n = 1'b0;
    wake_pin = 1'b0;
    c0 = $urandom(32'h8dd285fa);
    do_reset;
    // corners first, then random accesses over the whole map
    for (k = 0; k < 20; k++) begin
      ra = (k == 0) ? 7'h07 : (k == 1) ? 7'h0A : (k == 2) ? 7'h0B : 7'($urandom_range(17, 0));
      rdat = (k < 3) ? 8'hFF : 8'($urandom);
      wr(ra, rdat, 1'b0);
      rd(ra);
    end
    $display("test random_access done");
    // bad check byte, short frame, both polynomials
    wr(7'h0A, 8'h01, 1'b0);
    c0 = n_err;
    wr(7'h0F, ~scr_m, 1'b1);
    repeat (2) @(posedge clk_sys);
    chk("crc_err", 8'h01, 8'(n_err - c0));
    i_idc_host.xfer({1'b1, 7'h0F, ~scr_m, 8'h00}, 16, rx);
    repeat (2) @(posedge clk_sys);
    chk("len_err", 8'h02, 8'(n_err - c0));
    for (k = 0; k < 2; k++) begin
      wr(7'h0B, 8'(k), 1'b0);
      rd(7'h0F);
    end
    wr(7'h0A, 8'h00, 1'b0);
    $display("test frame_check done");
    // edge modes: rising, falling, both
    for (k = 0; k < 4; k++) begin
      wr(7'h11, {em[k][1:0], 6'h04}, 1'b0);
      c0 = n_wake;
      wake_pin <= ~wake_pin;
      repeat (20) @(posedge clk_sys);
      wk_m[5:4] = wake_pin ? 2'h1 : 2'h2;
      chk("edge_req", 8'h01, 8'(n_wake - c0));
      rd(7'h11);
    end
    // pulse widths against thresholds and limits
    for (k = 0; k < 8; k++) begin
      wr(7'h11, {4'hC, pi[k][1:0], pm[k][1:0]}, 1'b0);
      c0 = n_wake;
      wake_pin <= 1'b1;
      repeat (pw[k] * TK) @(posedge clk_sys);
      wake_pin <= 1'b0;
      repeat (20) @(posedge clk_sys);
      if (pulse_ok(pw[k], pi[k], pm[k])) wk_m[5:4] = 2'h3;
      chk("pulse_req", {7'h00, pulse_ok(pw[k], pi[k], pm[k])}, 8'(n_wake - c0));
      rd(7'h11);
    end
    $display("test wake_events done");
    do_reset;
    tally_and_finish;
  end
  // run time limit
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("[ERR] run_time exp done got hang");
    tally_and_finish;
  end
endmodule // tb_top
